/* hw/mbs_dev.sv */
// Operation
// RULE1: unsupported function code never touches registers
// RULE2: read accepts up to 125 registers
// RULE3: registers are 16 bits, read whole
// RULE4: master reads paired halves in one query
// RULE5: multi-register read walks addresses upward
// RULE6: read query: slave, 03h, start address hi-lo
// RULE7: then 16-bit count, high byte first
// RULE8: frames end with crc, low byte first
// RULE9: read answer echoes header, byte count twice registers
// RULE10: read data high then low, ascending
// RULE11: 06h writes one 16-bit register
// RULE12: write query: slave, code, address, value
// RULE13: master writes paired halves with 10h; the device here answers 10h with code 01h
// RULE14: write answer echoes the query exactly
// RULE15: exception answer adds 80h to function
// RULE16: bad address range gives code 02h
// RULE17: zero count or bad length gives 03h
// RULE18: unsupported function gives code 01h
`timescale 1ns/100ps
`default_nettype none
module mbs_dev (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // link to the master
   mbs_link_if.dev          lk,
   // own station address, held steady
   input  wire logic [7:0]  slave_addr,
   // register port of the unit
   output logic             reg_rd_req,
   output logic             reg_wr_req,
   output logic [15:0]      reg_addr,
   output logic [15:0]      reg_wdata,
   input  wire logic [15:0] reg_rd_data,
   input  wire logic        reg_rd_valid,
   // status
   output logic             busy
);

   typedef struct packed {
      mbs_pkg::mbs_dev_state_t st;
      logic [7:0][7:0]         qbuf;
      logic [3:0]              rx_n;
      logic [15:0]             crc;
      logic [2:0]              txi;
      logic [2:0]              hlen;
      logic [15:0]             ptr;
      logic [6:0]              left;
      logic [15:0]             rword;
      logic                    r_valid;
      logic [7:0]              r_data;
      logic                    r_last;
      logic                    rd_req;
      logic                    wr_req;
      logic [15:0]             reg_addr;
      logic [15:0]             reg_wdata;
      logic                    busy;
   } mbs_dev_t;

   mbs_dev_t s_reg;
   mbs_dev_t s_next;

   logic [7:0]  fn;
   logic [15:0] qa;
   logic [15:0] qw;
   logic [16:0] qend;
   logic [7:0]  tb;
   logic        emit;
   logic [7:0]  exc_code;
   logic        exc;

   always_comb begin
      s_next          = s_reg;
      s_next.r_valid  = 1'b0;
      s_next.r_last   = 1'b0;
      s_next.rd_req   = 1'b0;
      s_next.wr_req   = 1'b0;
      fn              = s_reg.qbuf[1];
      qa              = {s_reg.qbuf[2], s_reg.qbuf[3]};
      qw              = {s_reg.qbuf[4], s_reg.qbuf[5]};
      qend            = {1'b0, qa} + {1'b0, qw};
      tb              = 8'h00;
      emit            = 1'b0;
      exc_code        = 8'h00;
      exc             = 1'b0;
      case (s_reg.st)
         mbs_pkg::DS_IDLE: begin
            // queries arriving while an answer is going out are dropped whole
            if (lk.q_valid) begin
               s_next.crc = mbs_pkg::mbs_crc_byte(s_reg.crc, lk.q_data); // RULE8
               if (s_reg.rx_n < mbs_pkg::QUERY_LEN) begin
                  s_next.qbuf[s_reg.rx_n[2:0]] = lk.q_data; // RULE6 RULE7 RULE12
               end
               if (s_reg.rx_n != mbs_pkg::RX_SAT) begin
                  s_next.rx_n = s_reg.rx_n + 4'h1;
               end
               if (lk.q_last) begin
                  s_next.st   = mbs_pkg::DS_CHECK;
                  s_next.busy = 1'b1;
               end
            end
         end
         mbs_pkg::DS_CHECK: begin
            s_next.rx_n      = 4'h0;
            s_next.crc       = mbs_pkg::CRC_INIT;
            s_next.txi       = 3'h0;
            s_next.left      = 7'h00;
            s_next.ptr       = qa;
            s_next.reg_addr  = qa;
            s_next.reg_wdata = qw;
            // a residue of zero means the received check value matched
            if (s_reg.crc != 16'h0000 || s_reg.qbuf[0] != slave_addr) begin // RULE8
               s_next.st   = mbs_pkg::DS_IDLE;
               s_next.busy = 1'b0;
            end else if (fn != mbs_pkg::FN_READ && fn != mbs_pkg::FN_WRITE) begin
               exc      = 1'b1; // RULE1
               exc_code = mbs_pkg::EX_FUNC; // RULE18
            end else if (s_reg.rx_n != mbs_pkg::QUERY_LEN) begin
               exc      = 1'b1;
               exc_code = mbs_pkg::EX_DATA; // RULE17
            end else if (fn == mbs_pkg::FN_READ
                         && (qw == 16'h0000 || qw > mbs_pkg::READ_MAX)) begin // RULE2
               exc      = 1'b1;
               exc_code = mbs_pkg::EX_DATA; // RULE17
            end else if (qa > mbs_pkg::ADDR_MAX
                         || (fn == mbs_pkg::FN_READ && qend >= mbs_pkg::ADDR_END)) begin
               exc      = 1'b1;
               exc_code = mbs_pkg::EX_ADDR; // RULE16
            end else if (fn == mbs_pkg::FN_WRITE) begin
               // the echo is the stored query, so its check value repeats too
               s_next.wr_req = 1'b1; // RULE11
               s_next.hlen   = mbs_pkg::HEAD_WR; // RULE14
               s_next.st     = mbs_pkg::DS_HEAD;
            end else begin
               s_next.qbuf[2] = {qw[6:0], 1'b0}; // RULE9
               s_next.left    = qw[6:0];
               s_next.hlen    = mbs_pkg::HEAD_RD;
               s_next.st      = mbs_pkg::DS_HEAD;
            end
            if (exc) begin
               s_next.qbuf[1] = fn | mbs_pkg::FN_EXC; // RULE15
               s_next.qbuf[2] = exc_code;
               s_next.hlen    = mbs_pkg::HEAD_RD;
               s_next.st      = mbs_pkg::DS_HEAD;
            end
         end
         mbs_pkg::DS_HEAD: begin
            tb         = s_reg.qbuf[s_reg.txi]; // RULE9 RULE14
            emit       = 1'b1;
            s_next.txi = s_reg.txi + 3'h1;
            if (s_reg.txi == s_reg.hlen - 3'h1) begin
               s_next.st = (s_reg.left != 7'h00) ? mbs_pkg::DS_RDREQ : mbs_pkg::DS_CRCL;
            end
         end
         mbs_pkg::DS_RDREQ: begin
            s_next.rd_req   = 1'b1;
            s_next.reg_addr = s_reg.ptr; // RULE5
            s_next.st       = mbs_pkg::DS_RDWAIT;
         end
         mbs_pkg::DS_RDWAIT: begin
            // the unit may take any number of cycles to answer
            if (reg_rd_valid) begin
               s_next.rword = reg_rd_data; // RULE3
               s_next.st    = mbs_pkg::DS_RDHI;
            end
         end
         mbs_pkg::DS_RDHI: begin
            tb        = s_reg.rword[15:8]; // RULE10
            emit      = 1'b1;
            s_next.st = mbs_pkg::DS_RDLO;
         end
         mbs_pkg::DS_RDLO: begin
            tb          = s_reg.rword[7:0]; // RULE10
            emit        = 1'b1;
            s_next.ptr  = s_reg.ptr + 16'h0001; // RULE5
            s_next.left = s_reg.left - 7'h01;
            s_next.st   = (s_reg.left == 7'h01) ? mbs_pkg::DS_CRCL : mbs_pkg::DS_RDREQ;
         end
         mbs_pkg::DS_CRCL: begin
            s_next.r_valid = 1'b1;
            s_next.r_data  = s_reg.crc[7:0]; // RULE8
            s_next.st      = mbs_pkg::DS_CRCH;
         end
         mbs_pkg::DS_CRCH: begin
            s_next.r_valid = 1'b1;
            s_next.r_data  = s_reg.crc[15:8]; // RULE8
            s_next.r_last  = 1'b1;
            s_next.crc     = mbs_pkg::CRC_INIT;
            s_next.busy    = 1'b0;
            s_next.st      = mbs_pkg::DS_IDLE;
         end
         default: begin
            s_next.crc  = mbs_pkg::CRC_INIT;
            s_next.rx_n = 4'h0;
            s_next.busy = 1'b0;
            s_next.st   = mbs_pkg::DS_IDLE;
         end
      endcase
      if (emit) begin
         s_next.r_valid = 1'b1;
         s_next.r_data  = tb;
         s_next.crc     = mbs_pkg::mbs_crc_byte(s_reg.crc, tb); // RULE8
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_reg      <= '0;
         s_reg.st   <= mbs_pkg::DS_IDLE;
         s_reg.crc  <= mbs_pkg::CRC_INIT;
         s_reg.hlen <= mbs_pkg::HEAD_RD;
      end else begin
         s_reg <= s_next;
      end
   end

   assign lk.r_valid = s_reg.r_valid;
   assign lk.r_data  = s_reg.r_data;
   assign lk.r_last  = s_reg.r_last;
   assign reg_rd_req = s_reg.rd_req;
   assign reg_wr_req = s_reg.wr_req;
   assign reg_addr   = s_reg.reg_addr;
   assign reg_wdata  = s_reg.reg_wdata;
   assign busy       = s_reg.busy;

endmodule // mbs_dev
`default_nettype wire

/* hw/mbs_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface mbs_link_if;
   // query bytes, master to slave
   logic       q_valid;
   logic [7:0] q_data;
   logic       q_last;
   // response bytes, slave to master
   logic       r_valid;
   logic [7:0] r_data;
   logic       r_last;

   modport dev (input q_valid, input q_data, input q_last,
                output r_valid, output r_data, output r_last);
   modport mst (output q_valid, output q_data, output q_last,
                input r_valid, input r_data, input r_last);
endinterface
`default_nettype wire

/* hw/mbs_mst.sv */
`timescale 1ns/100ps
`default_nettype none
module mbs_mst #(
   parameter int RESP_WAIT = mbs_pkg::RESP_WAIT
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // link to the slave
   mbs_link_if.mst          lk,
   // command side
   input  wire logic        cmd_valid,
   input  wire logic [7:0]  cmd_slave,
   input  wire logic [7:0]  cmd_func,
   input  wire logic [15:0] cmd_addr,
   input  wire logic [15:0] cmd_word,
   output logic             cmd_ready,
   // answer side
   output logic             word_valid,
   output logic [15:0]      word_data,
   output logic             done,
   output logic             done_crc_ok,
   output logic             done_exc,
   output logic             done_timeout,
   output logic [7:0]       done_code
);

   typedef struct packed {
      mbs_pkg::mbs_mst_state_t st;
      logic [5:0][7:0]         frame;
      logic [2:0]              txi;
      logic [15:0]             crc;
      logic                    q_valid;
      logic [7:0]              q_data;
      logic                    q_last;
      logic [8:0]              rxi;
      logic [7:0]              func;
      logic [7:0]              bc;
      logic [7:0]              hi;
      logic [15:0]             wait_n;
      logic                    cmd_ready;
      logic                    word_valid;
      logic [15:0]             word_data;
      logic                    done;
      logic                    crc_ok;
      logic                    exc;
      logic                    tmo;
   } mbs_mst_t;

   mbs_mst_t s_reg;
   mbs_mst_t s_next;
   logic [15:0] crc_n;

   always_comb begin
      s_next            = s_reg;
      s_next.q_valid    = 1'b0;
      s_next.q_last     = 1'b0;
      s_next.word_valid = 1'b0;
      s_next.done       = 1'b0;
      crc_n             = mbs_pkg::mbs_crc_byte(s_reg.crc, lk.r_data);
      case (s_reg.st)
         mbs_pkg::MS_IDLE: begin
            // one query per command; paired halves go in one read, writes send one word per six-byte query
            if (cmd_valid) begin // RULE4 RULE13
               s_next.frame     = {cmd_word[7:0], cmd_word[15:8], cmd_addr[7:0],
                                   cmd_addr[15:8], cmd_func, cmd_slave}; // RULE6 RULE7 RULE12
               s_next.txi       = 3'h0;
               s_next.crc       = mbs_pkg::CRC_INIT;
               s_next.cmd_ready = 1'b0;
               s_next.st        = mbs_pkg::MS_SEND;
            end
         end
         mbs_pkg::MS_SEND: begin
            s_next.q_valid = 1'b1;
            s_next.txi     = s_reg.txi + 3'h1;
            if (s_reg.txi < mbs_pkg::BODY_LEN) begin
               s_next.q_data = s_reg.frame[s_reg.txi];
               s_next.crc    = mbs_pkg::mbs_crc_byte(s_reg.crc, s_reg.frame[s_reg.txi]);
            end else if (s_reg.txi == mbs_pkg::BODY_LEN) begin
               s_next.q_data = s_reg.crc[7:0]; // RULE8
            end else begin
               s_next.q_data = s_reg.crc[15:8]; // RULE8
               s_next.q_last = 1'b1;
               s_next.crc    = mbs_pkg::CRC_INIT;
               s_next.rxi    = 9'h000;
               s_next.wait_n = 16'h0000;
               s_next.st     = mbs_pkg::MS_WAIT;
            end
         end
         mbs_pkg::MS_WAIT: begin
            s_next.wait_n = s_reg.wait_n + 16'h0001;
            if (lk.r_valid) begin
               // each answer byte restarts the wait count, so long reads are not cut short
               s_next.wait_n = 16'h0000;
               s_next.crc    = crc_n;
               if (s_reg.rxi != 9'h1FF) begin
                  s_next.rxi = s_reg.rxi + 9'h001;
               end
               if (s_reg.rxi == 9'h001) begin
                  s_next.func = lk.r_data;
               end
               if (s_reg.rxi == 9'h002) begin
                  s_next.bc = lk.r_data;
               end
               // read data pairs high then low into one word
               if (s_reg.func == mbs_pkg::FN_READ && s_reg.rxi >= mbs_pkg::RD_DATA0
                   && s_reg.rxi < mbs_pkg::RD_DATA0 + {1'b0, s_reg.bc}) begin // RULE10
                  if (!s_reg.rxi[0]) begin
                     s_next.word_valid = 1'b1;
                     s_next.word_data  = {s_reg.hi, lk.r_data};
                  end else begin
                     s_next.hi = lk.r_data;
                  end
               end
               if (lk.r_last) begin
                  s_next.done      = 1'b1;
                  s_next.crc_ok    = (crc_n == 16'h0000); // RULE8
                  s_next.exc       = s_reg.func[7]; // RULE15
                  s_next.tmo       = 1'b0;
                  s_next.cmd_ready = 1'b1;
                  s_next.st        = mbs_pkg::MS_IDLE;
               end
            end else if (s_reg.wait_n == 16'(RESP_WAIT)) begin
               s_next.done      = 1'b1;
               s_next.crc_ok    = 1'b0;
               s_next.exc       = 1'b0;
               s_next.tmo       = 1'b1;
               s_next.cmd_ready = 1'b1;
               s_next.st        = mbs_pkg::MS_IDLE;
            end
         end
         default: begin
            s_next.cmd_ready = 1'b1;
            s_next.st        = mbs_pkg::MS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_reg           <= '0;
         s_reg.st        <= mbs_pkg::MS_IDLE;
         s_reg.crc       <= mbs_pkg::CRC_INIT;
         s_reg.cmd_ready <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign lk.q_valid   = s_reg.q_valid;
   assign lk.q_data    = s_reg.q_data;
   assign lk.q_last    = s_reg.q_last;
   assign cmd_ready    = s_reg.cmd_ready;
   assign word_valid   = s_reg.word_valid;
   assign word_data    = s_reg.word_data;
   assign done         = s_reg.done;
   assign done_crc_ok  = s_reg.crc_ok;
   assign done_exc     = s_reg.exc;
   assign done_timeout = s_reg.tmo;
   assign done_code    = s_reg.bc;

endmodule // mbs_mst
`default_nettype wire

/* hw/mbs_pkg.sv */
package mbs_pkg;

   // function codes and exception answers
   localparam logic [7:0]  FN_READ    = 8'h03;
   localparam logic [7:0]  FN_WRITE   = 8'h06;
   localparam logic [7:0]  FN_EXC     = 8'h80;
   localparam logic [7:0]  EX_FUNC    = 8'h01;
   localparam logic [7:0]  EX_ADDR    = 8'h02;
   localparam logic [7:0]  EX_DATA    = 8'h03;

   // limits of the register space and of one read
   localparam logic [15:0] ADDR_MAX   = 16'h57FF;
   localparam logic [16:0] ADDR_END   = 17'h05800;
   localparam logic [15:0] READ_MAX   = 16'h007D;

   // frame layout: both supported queries are six bytes plus two of check
   localparam logic [3:0]  QUERY_LEN  = 4'h8;
   localparam logic [3:0]  RX_SAT     = 4'h9;
   localparam logic [2:0]  BODY_LEN   = 3'h6;
   localparam logic [2:0]  HEAD_RD    = 3'h3;
   localparam logic [2:0]  HEAD_WR    = 3'h6;
   localparam logic [8:0]  RD_DATA0   = 9'h003;

   // crc-16, reflected polynomial, low byte sent first
   localparam logic [15:0] CRC_INIT   = 16'hFFFF;
   localparam logic [15:0] CRC_POLY   = 16'hA001;

   // master gives up on a silent slave after this many cycles
   localparam int          RESP_WAIT  = 4000;

   typedef enum logic [9:0] {
      DS_IDLE   = 10'h001,
      DS_CHECK  = 10'h002,
      DS_HEAD   = 10'h004,
      DS_RDREQ  = 10'h008,
      DS_RDWAIT = 10'h010,
      DS_RDHI   = 10'h020,
      DS_RDLO   = 10'h040,
      DS_CRCL   = 10'h080,
      DS_CRCH   = 10'h100,
      DS_SPARE  = 10'h200
   } mbs_dev_state_t;

   typedef enum logic [2:0] {
      MS_IDLE = 3'h1,
      MS_SEND = 3'h2,
      MS_WAIT = 3'h4
   } mbs_mst_state_t;

   function automatic logic [15:0] mbs_crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] x;
      x = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
      end
      return x;
   endfunction

endpackage

/* testbench/mbs_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module mbs_chk (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // link signals
   input  wire logic       q_valid,
   input  wire logic [7:0] q_data,
   input  wire logic       q_last,
   input  wire logic       r_valid,
   input  wire logic [7:0] r_data,
   input  wire logic       r_last
);
   logic [7:0]  qb [8];
   logic [3:0]  qn;
   logic [7:0]  rn, rfn, fn, end_at;
   logic [15:0] qaddr, qcnt, crc_r, crc_nx;
   logic [16:0] qsum;

   // own bitwise crc so a shared slip cannot hide itself
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      c = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      return c;
   endfunction

   assign fn = qb[1];
   assign qaddr = {qb[2], qb[3]};
   assign qcnt = {qb[4], qb[5]};
   assign qsum = {1'b0, qaddr} + {1'b0, qcnt};
   assign end_at = rfn[7] ? 8'h04 : ((rfn == 8'h03) ? 8'h04 + {qb[5][6:0], 1'b0} : 8'h07);
   always_comb crc_nx = crc_step(crc_r, r_data);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         qn <= 4'h0;
         rn <= 8'h00;
         rfn <= 8'h00;
         crc_r <= 16'hFFFF;
      end else begin
         if (q_valid) begin
            if (qn < 4'h8) qb[qn[2:0]] <= q_data;
            qn <= q_last ? 4'h0 : qn + 4'h1;
         end
         if (r_valid) begin
            rn <= r_last ? 8'h00 : rn + 8'h01;
            crc_r <= r_last ? 16'hFFFF : crc_nx;
            if (rn == 8'h01) rfn <= r_data;
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence q_end;   q_valid && q_last;  endsequence
   sequence hdr_first; r_valid && rn == 8'h00; endsequence
   sequence hdr_rest;  r_valid ##1 r_valid;    endsequence
   sequence code_one;  r_valid && r_data == 8'h01; endsequence

   query_last_valid_a: assert property (q_last |-> q_valid)
      else $error("query end without byte");
   quiet_turnaround_a: assert property (q_end |=> !r_valid) else $error("answer too early");
   header_burst_a: assert property (hdr_first |=> hdr_rest) else $error("header broken");
   echo_station_a: assert property (hdr_first |-> r_data == qb[0])
      else $error("station differs");
   echo_func_a: assert property (r_valid && rn == 8'h01
      |-> r_data == fn || r_data == (fn | 8'h80)) else $error("function byte wrong");
   bad_func_a: assert property (r_valid && rn == 8'h01 && fn != 8'h03 && fn != 8'h06
      |-> r_data == (fn | 8'h80) ##1 code_one) else $error("bad function answer");
   frame_length_a: assert property (r_valid && r_last |-> rn == end_at)
      else $error("length wrong");
   byte_count_a: assert property (r_valid && rn == 8'h02 && rfn == 8'h03
      |-> r_data == {qb[5][6:0], 1'b0}) else $error("byte count wrong");
   write_echo_a: assert property (r_valid && rn >= 8'h02 && rn < 8'h08 && rfn == 8'h06
      |-> r_data == qb[rn[2:0]]) else $error("write echo differs");
   count_exc_a: assert property (r_valid && rn == 8'h02 && fn == 8'h03
      && (qcnt == 16'h0000 || qcnt > 16'h007D) |-> r_data == 8'h03) else $error("count code wrong");
   range_exc_a: assert property (r_valid && rn == 8'h02 && fn == 8'h03
      && qcnt != 16'h0000 && qcnt <= 16'h007D && qsum >= 17'h05800 |-> r_data == 8'h02)
      else $error("range code");
   crc_residue_a: assert property (r_valid && r_last |-> crc_nx == 16'h0000)
      else $error("bad crc");
endmodule // mbs_chk
`default_nettype wire

/* testbench/mbs_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module mbs_tb_top;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  slave_addr = 8'h11;
   logic        cmd_valid = 1'b0;
   logic [7:0]  cmd_slave = 8'h00, cmd_func = 8'h00, done_code;
   logic [15:0] cmd_addr = 16'h0000, cmd_word = 16'h0000, word_data;
   logic        cmd_ready, word_valid, done, done_crc_ok, done_exc, done_timeout, dev_busy;
   logic        reg_rd_req, reg_wr_req, reg_rd_valid = 1'b0, slow = 1'b0, rd_busy = 1'b0;
   logic [15:0] reg_addr, reg_wdata, reg_rd_data = 16'h0000, rd_at, wr_a, wr_d;
   logic [1:0]  rd_wait;
   int          n_errors = 0, samples_checked = 0, n_rd = 0, n_wr = 0;
   logic [15:0] words [$];

   always #10 clk_sys = ~clk_sys;

   mbs_link_if lk ();
   mbs_dev mbs_dev_inst (.clk_sys(clk_sys), .rst(rst), .lk(lk), .slave_addr(slave_addr),
      .reg_rd_req(reg_rd_req), .reg_wr_req(reg_wr_req), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
      .busy(dev_busy));
   // short master timeout keeps the silent-station case quick
   mbs_mst #(.RESP_WAIT(200)) mbs_mst_inst (.clk_sys(clk_sys), .rst(rst), .lk(lk),
      .cmd_valid(cmd_valid), .cmd_slave(cmd_slave), .cmd_func(cmd_func), .cmd_addr(cmd_addr),
      .cmd_word(cmd_word), .cmd_ready(cmd_ready), .word_valid(word_valid),
      .word_data(word_data), .done(done), .done_crc_ok(done_crc_ok), .done_exc(done_exc),
      .done_timeout(done_timeout), .done_code(done_code));
   mbs_chk mbs_chk_inst (.clk_sys(clk_sys), .rst(rst), .q_valid(lk.q_valid),
      .q_data(lk.q_data), .q_last(lk.q_last), .r_valid(lk.r_valid), .r_data(lk.r_data),
      .r_last(lk.r_last));

   // register stand-in: value is the address scrambled; stale data keeps toggling
   always @(posedge clk_sys) begin
      reg_rd_valid <= 1'b0;
      reg_rd_data <= ~reg_rd_data;
      if (reg_wr_req === 1'b1) begin
         n_wr <= n_wr + 1;
         wr_a <= reg_addr;
         wr_d <= reg_wdata;
      end
      if (reg_rd_req === 1'b1) begin
         n_rd <= n_rd + 1;
         rd_at <= reg_addr;
         rd_wait <= slow ? 2'h3 : 2'h0;
         rd_busy <= 1'b1;
      end else if (rd_busy) begin
         if (rd_wait == 2'h0) begin
            rd_busy <= 1'b0;
            reg_rd_valid <= 1'b1;
            reg_rd_data <= rd_at ^ 16'hA5C3;
         end else begin
            rd_wait <= rd_wait - 2'h1;
         end
      end
      if (word_valid === 1'b1) words.push_back(word_data);
   end

   task automatic end_sim();
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic run(input logic [7:0] s, f, input logic [15:0] a, w);
      int t;
      words.delete();
      cmd_valid <= 1'b1;
      cmd_slave <= s;
      cmd_func <= f;
      cmd_addr <= a;
      cmd_word <= w;
      @(posedge clk_sys);
      while (cmd_ready !== 1'b1) @(posedge clk_sys);
      cmd_valid <= 1'b0;
      t = 0;
      do begin
         @(posedge clk_sys);
         t++;
      end while (done !== 1'b1 && t < 3000);
      chk("done", t < 3000, 1);
      chk("busy", dev_busy, 0);
   endtask

   task automatic exp_read(input logic [15:0] a, n);
      int r0;
      logic [15:0] e;
      r0 = n_rd;
      run(slave_addr, 8'h03, a, n);
      chk("read exc", done_exc, 0);
      chk("read crc", done_crc_ok, 1);
      chk("byte count", done_code, 2 * n);
      chk("reads", n_rd - r0, n);
      chk("words", words.size(), n);
      foreach (words[i]) begin
         e = a + i[15:0];
         chk("word", words[i], e ^ 16'hA5C3);
      end
   endtask

   task automatic exp_exc(input logic [7:0] f, input logic [15:0] a, w, input logic [7:0] c);
      int r0, w0;
      r0 = n_rd;
      w0 = n_wr;
      run(slave_addr, f, a, w);
      chk("exc flag", done_exc, 1);
      chk("exc code", done_code, c);
      chk("exc crc", done_crc_ok, 1);
      chk("no access", (n_rd - r0) + (n_wr - w0), 0);
   endtask

   task automatic t_read_span();
      slow <= 1'b1;
      exp_read(16'h1840, 16'h0006);
      slow <= 1'b0;
      exp_read(16'h57FE, 16'h0001);
      $display("test read_span done");
   endtask

   task automatic t_read_max();
      exp_read(16'h0000, 16'h007D);
      exp_read(16'h0100, 16'h0002);
      $display("test read_max done");
   endtask

   task automatic t_range();
      exp_exc(8'h03, 16'h57FF, 16'h0001, 8'h02);
      exp_exc(8'h03, 16'h57FE, 16'h0002, 8'h02);
      exp_exc(8'h03, 16'h5800, 16'h0001, 8'h02);
      exp_exc(8'h06, 16'h5800, 16'h1234, 8'h02);
      $display("test range done");
   endtask

   task automatic t_count();
      exp_exc(8'h03, 16'h0000, 16'h0000, 8'h03);
      exp_exc(8'h03, 16'h0000, 16'h007E, 8'h03);
      exp_exc(8'h03, 16'hFFFF, 16'h0000, 8'h03);
      $display("test count done");
   endtask

   task automatic t_func();
      logic [7:0] codes [5] = '{8'h01, 8'h08, 8'h10, 8'h04, 8'h7F};
      foreach (codes[i]) exp_exc(codes[i], 16'h0000, 16'h0001, 8'h01);
      $display("test func done");
   endtask

   task automatic t_write();
      int w0;
      w0 = n_wr;
      run(slave_addr, 8'h06, 16'h0255, 16'h0050);
      chk("wr exc", done_exc, 0);
      chk("wr crc", done_crc_ok, 1);
      chk("wr echo", done_code, 8'h02);
      chk("wr count", n_wr - w0, 1);
      chk("wr addr", wr_a, 16'h0255);
      chk("wr data", wr_d, 16'h0050);
      run(slave_addr, 8'h06, 16'h57FF, 16'hFFFF);
      chk("wr top", {wr_a, wr_d}, 32'h57FFFFFF);
      $display("test write done");
   endtask

   task automatic t_other_station();
      int r0;
      r0 = n_rd;
      run(slave_addr ^ 8'h01, 8'h03, 16'h0000, 16'h0001);
      chk("silent", done_timeout, 1);
      chk("no read", n_rd - r0, 0);
      $display("test other_station done");
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_read_span();
      t_read_max();
      t_range();
      t_count();
      t_func();
      t_write();
      t_other_station();
      end_sim();
   end

   // whole run needs under two thousand cycles
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_errors++;
      end_sim();
   end
endmodule // mbs_tb_top
`default_nettype wire
